//--- cbt_can_timing.sv
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cbt_can_timing
  import cbt_pkg::*;
#(
  parameter int OBJ_COUNT = 32
)(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             core_tick,
  output logic             tq_pulse,
  output logic             sample_pulse,
  output var cbt_seg_t     bit_seg
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [1:0]  can_clock_divider_config_reg;
  logic [7:0]  can_control_reg;
  logic [15:0] bit_timing_reg;
  logic [3:0]  prescaler_extension_reg;
  logic [15:0] cmd_req_reg  [2];
  logic [15:0] cmd_mask_reg [2];
  logic [15:0] if_data_reg  [2][4];
  logic [OBJ_COUNT-1:0] message_valid_flags_reg;
  logic [OBJ_COUNT-1:0] tx_request_reg;
  logic [OBJ_COUNT-1:0] new_data_reg;
  logic [63:0] msg_ram [OBJ_COUNT];

  logic        pend_valid_reg;
  logic [7:0]  pend_idx_reg;
  logic [15:0] pend_data_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        core_tick_reg;

  logic [9:0]  tq_cnt_reg;
  logic [3:0]  seg_cnt_reg;
  cbt_seg_t    seg_reg;
  logic        tq_pulse_reg;
  logic        sample_pulse_reg;

  ////////////////////////////////////////////////////////////////////////
  // Core clock divider
  logic tick;

  cbt_clk_div cbt_clk_div_inst (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .div_sel (can_clock_divider_config_reg),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [7:0] idx;
  logic       aligned;
  logic [4:0] bus_if;
  logic       ro_hit;
  logic       core_hit;
  logic       cfg_hit;
  logic       hit;
  logic       acc;
  logic       done;
  logic       wr_core_now;

  assign idx      = paddr[9:2];
  assign aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign bus_if   = cbt_if_dec(idx);
  assign ro_hit   = aligned && (idx == CBT_IDX_STAT || idx == CBT_IDX_TR1 ||
                    idx == CBT_IDX_TR2 || idx == CBT_IDX_ND1 ||
                    idx == CBT_IDX_ND2 || idx == CBT_IDX_IP1 ||
                    idx == CBT_IDX_IP2 || idx == CBT_IDX_MV1 ||
                    idx == CBT_IDX_MV2);
  assign core_hit = aligned && (idx == CBT_IDX_CTL || idx == CBT_IDX_BT ||
                    idx == CBT_IDX_PRESCALER_EXTENSION || bus_if[4]);
  assign cfg_hit  = aligned && (idx == CBT_IDX_CFG);
  assign hit      = ro_hit || core_hit || cfg_hit;
  assign acc      = psel && penable;
  assign done     = acc && pready_reg;
  // Read-only registers swallow writes silently
  assign wr_core_now = done && pwrite && core_hit;

  ////////////////////////////////////////////////////////////////////////
  // Read data selection
  logic [15:0] rd_val;
  logic [15:0] status_val;

  assign status_val = {12'h000, seg_reg, ~can_control_reg[CBT_CTL_INIT],
                       pend_valid_reg};

  always_comb begin
    rd_val = 16'h0000;
    case (idx)
      CBT_IDX_CTL:  rd_val = {8'h00, can_control_reg};
      CBT_IDX_STAT: rd_val = status_val;
      CBT_IDX_BT:   rd_val = bit_timing_reg;
      CBT_IDX_PRESCALER_EXTENSION: rd_val = {12'h000, prescaler_extension_reg};
      CBT_IDX_TR1:  rd_val = tx_request_reg[15:0];
      CBT_IDX_TR2:  rd_val = tx_request_reg[31:16];
      CBT_IDX_ND1:  rd_val = new_data_reg[15:0];
      CBT_IDX_ND2:  rd_val = new_data_reg[31:16];
      CBT_IDX_MV1:  rd_val = message_valid_flags_reg[15:0];
      CBT_IDX_MV2:  rd_val = message_valid_flags_reg[31:16];
      CBT_IDX_CFG:  rd_val = {14'h0000, can_clock_divider_config_reg};
      default: begin
        if (bus_if[4] && bus_if[2:0] == 3'h0)
          rd_val = cmd_req_reg[bus_if[3]];
        else if (bus_if[4] && bus_if[2:0] == 3'h1)
          rd_val = cmd_mask_reg[bus_if[3]];
        else if (bus_if[4])
          rd_val = if_data_reg[bus_if[3]][2'(bus_if[2:0] - 3'h2)];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, writes stall while a write is in flight
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (done) begin
        pready_reg  <= 1'b0;
        pslverr_reg <= 1'b0;
      end else if (acc && (!pwrite || !pend_valid_reg)) begin
        pready_reg  <= 1'b1;
        pslverr_reg <= !hit;
        prdata_reg  <= (pwrite || !hit) ? 32'h0000_0000 : {16'h0000, rd_val};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      can_clock_divider_config_reg <= CBT_CFG_RST;
    else if (clk_en && done && pwrite && cfg_hit)
      can_clock_divider_config_reg <= pwdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Posted write into the core domain, applied on the next core tick
  logic        eff_valid;
  logic [7:0]  eff_idx;
  logic [15:0] eff_data;
  logic        core_we;

  assign eff_valid = pend_valid_reg || wr_core_now;
  assign eff_idx   = pend_valid_reg ? pend_idx_reg : idx;
  assign eff_data  = pend_valid_reg ? pend_data_reg : pwdata[15:0];
  // Same-edge apply keeps the worst case at ratio minus one cycles
  assign core_we   = tick && eff_valid;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_valid_reg <= 1'b0;
      pend_idx_reg   <= 8'h00;
      pend_data_reg  <= 16'h0000;
    end else if (clk_en) begin
      if (core_we)
        pend_valid_reg <= 1'b0;
      else if (wr_core_now) begin
        pend_valid_reg <= 1'b1;
        pend_idx_reg   <= idx;
        pend_data_reg  <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core registers and message object transfers
  logic [4:0] eff_if;
  logic       set_s;
  logic       cfg_open;
  logic       xfer;
  logic       xfer_wr;
  logic [4:0] obj_idx;
  logic [5:0] obj_num;

  assign eff_if   = cbt_if_dec(eff_idx);
  assign set_s    = eff_if[3];
  assign cfg_open = can_control_reg[CBT_CTL_INIT] &&
                    can_control_reg[CBT_CTL_CCE];
  assign obj_num  = eff_data[5:0];
  assign obj_idx  = 5'(obj_num - 6'h01);
  assign xfer     = core_we && eff_if[4] && eff_if[2:0] == 3'h0 &&
                    obj_num != 6'h00 && obj_num <= 6'(OBJ_COUNT);
  assign xfer_wr  = xfer && cmd_mask_reg[set_s][CBT_CM_WR];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      can_control_reg         <= CBT_CTL_RST;
      bit_timing_reg          <= CBT_BT_RST;
      prescaler_extension_reg <= CBT_PRESCALER_EXTENSION_RST;
      message_valid_flags_reg <= '0;
      tx_request_reg          <= '0;
      new_data_reg            <= '0;
      for (int s = 0; s < 2; s++) begin
        cmd_req_reg[s]  <= CBT_CR_RST;
        cmd_mask_reg[s] <= 16'h0000;
        for (int k = 0; k < 4; k++)
          if_data_reg[s][k] <= 16'h0000;
      end
    end else if (clk_en && core_we) begin
      if (eff_idx == CBT_IDX_CTL)
        can_control_reg <= eff_data[7:0];
      // Timing is locked unless init and change enable are both set
      if (eff_idx == CBT_IDX_BT && cfg_open)
        bit_timing_reg <= eff_data;
      if (eff_idx == CBT_IDX_PRESCALER_EXTENSION && cfg_open)
        prescaler_extension_reg <= eff_data[3:0];
      if (eff_if[4] && eff_if[2:0] == 3'h0)
        cmd_req_reg[set_s] <= eff_data;
      if (eff_if[4] && eff_if[2:0] == 3'h1)
        cmd_mask_reg[set_s] <= eff_data;
      if (eff_if[4] && eff_if[2:0] >= 3'h2)
        if_data_reg[set_s][2'(eff_if[2:0] - 3'h2)] <= eff_data;
      if (xfer_wr) begin
        message_valid_flags_reg[obj_idx] <=
          !cmd_mask_reg[set_s][CBT_CM_CLRVAL];
        tx_request_reg[obj_idx] <= cmd_mask_reg[set_s][CBT_CM_TXRQ];
        new_data_reg[obj_idx]   <= 1'b1;
      end else if (xfer) begin
        for (int k = 0; k < 4; k++)
          if_data_reg[set_s][k] <= msg_ram[obj_idx][16*k +: 16];
        if (cmd_mask_reg[set_s][CBT_CM_TXRQ])
          new_data_reg[obj_idx] <= 1'b0;
      end
    end
  end

  // Object storage carries no reset; valid flags say what is meaningful
  always_ff @(posedge clk_sys) begin
    if (clk_en && xfer_wr)
      msg_ram[obj_idx] <= {if_data_reg[set_s][3], if_data_reg[set_s][2],
                           if_data_reg[set_s][1], if_data_reg[set_s][0]};
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit time sequencer, stepped by core ticks while out of init
  logic       run;
  logic       bt_step;
  logic [9:0] presc_m1;
  logic       tq_end;
  logic [3:0] seg_len_m1;
  logic       seg_last;

  assign run      = !can_control_reg[CBT_CTL_INIT];
  assign bt_step  = clk_en && tick && run;
  assign presc_m1 = {prescaler_extension_reg,
                     bit_timing_reg[CBT_BT_BRP_LSB +: 6]};
  assign tq_end   = (tq_cnt_reg == presc_m1);
  assign seg_len_m1 =
    (seg_reg == SEG_SYNC)  ? 4'h0 :
    (seg_reg == SEG_FIRST_SEGMENT_FIELD) ? bit_timing_reg[CBT_BT_TS1_LSB +: 4] :
    {1'b0, bit_timing_reg[CBT_BT_TS2_LSB +: 3]};
  assign seg_last = (seg_cnt_reg == seg_len_m1);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tq_cnt_reg  <= 10'h000;
      seg_cnt_reg <= 4'h0;
      seg_reg     <= SEG_SYNC;
    end else if (clk_en && !run) begin
      tq_cnt_reg  <= 10'h000;
      seg_cnt_reg <= 4'h0;
      seg_reg     <= SEG_SYNC;
    end else if (bt_step) begin
      tq_cnt_reg <= tq_end ? 10'h000 : tq_cnt_reg + 10'h001;
      if (tq_end && !seg_last)
        seg_cnt_reg <= seg_cnt_reg + 4'h1;
      else if (tq_end) begin
        seg_cnt_reg <= 4'h0;
        unique case (seg_reg)
          SEG_SYNC:  seg_reg <= SEG_FIRST_SEGMENT_FIELD;
          SEG_FIRST_SEGMENT_FIELD: seg_reg <= SEG_SECOND_SEGMENT_FIELD;
          SEG_SECOND_SEGMENT_FIELD: seg_reg <= SEG_SYNC;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tq_pulse_reg     <= 1'b0;
      sample_pulse_reg <= 1'b0;
      core_tick_reg    <= 1'b0;
    end else if (clk_en) begin
      tq_pulse_reg     <= bt_step && tq_end;
      sample_pulse_reg <= bt_step && tq_end && seg_last &&
                          seg_reg == SEG_FIRST_SEGMENT_FIELD;
      core_tick_reg    <= tick;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign core_tick    = core_tick_reg;
  assign tq_pulse     = tq_pulse_reg;
  assign sample_pulse = sample_pulse_reg;
  assign bit_seg      = seg_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn || !clk_en);

  tick_ratio_a: assert property (
    (tick && can_clock_divider_config_reg == 2'h1 &&
     $stable(can_clock_divider_config_reg) &&
     !(done && pwrite && cfg_hit)) |=> (!tick ##1 tick))
    else $error("divide by two tick spacing wrong");

  no_pend_div1_a: assert property (
    (wr_core_now && can_clock_divider_config_reg == 2'h0) |=>
      !pend_valid_reg)
    else $error("write not applied at once with ratio one");

  commit_bound_a: assert property (
    $rose(pend_valid_reg) |-> ##[1:7] !pend_valid_reg)
    else $error("posted write not applied in time");

  read_nostall_a: assert property (
    (acc && !pwrite && !pready_reg) |=> pready_reg)
    else $error("read was stalled");

  sync_one_tq_a: assert property (
    (bt_step && seg_reg == SEG_SYNC && tq_end) |=> seg_reg == SEG_FIRST_SEGMENT_FIELD)
    else $error("sync segment longer than one quantum");

  seg_order_a: assert property (
    (bt_step && seg_reg == SEG_FIRST_SEGMENT_FIELD && tq_end && seg_last) |=>
      (seg_reg == SEG_SECOND_SEGMENT_FIELD && seg_cnt_reg == 4'h0))
    else $error("segment order broken");

  tq_span_a: assert property (
    run |-> tq_cnt_reg <= presc_m1)
    else $error("quantum counter past prescaler");

  bt_locked_a: assert property (
    $changed(bit_timing_reg) |-> $past(cfg_open))
    else $error("bit timing changed while locked");

  obj_store_a: assert property (
    (xfer_wr && !cmd_mask_reg[set_s][CBT_CM_CLRVAL]) |=>
      message_valid_flags_reg[$past(obj_idx)])
    else $error("object write did not set valid flag");

  ro_ignore_a: assert property (
    (done && pwrite && ro_hit && !pend_valid_reg) |=> !pend_valid_reg)
    else $error("read-only write was posted");

endmodule
`default_nettype wire

//--- cbt_pkg.sv
package cbt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CBT_IDX_CTL  = 8'h00;
  localparam logic [7:0] CBT_IDX_STAT = 8'h02;
  localparam logic [7:0] CBT_IDX_BT   = 8'h06;
  localparam logic [7:0] CBT_IDX_PRESCALER_EXTENSION = 8'h0C;
  localparam logic [7:0] CBT_IDX_IF1  = 8'h10;
  localparam logic [7:0] CBT_IDX_IF2  = 8'h40;
  localparam logic [7:0] CBT_IDX_TR1  = 8'h80;
  localparam logic [7:0] CBT_IDX_TR2  = 8'h82;
  localparam logic [7:0] CBT_IDX_ND1  = 8'h90;
  localparam logic [7:0] CBT_IDX_ND2  = 8'h92;
  localparam logic [7:0] CBT_IDX_IP1  = 8'hA0;
  localparam logic [7:0] CBT_IDX_IP2  = 8'hA2;
  localparam logic [7:0] CBT_IDX_MV1  = 8'hB0;
  localparam logic [7:0] CBT_IDX_MV2  = 8'hB2;
  localparam logic [7:0] CBT_IDX_CFG  = 8'hC0;

  // Offsets inside one interface set
  localparam logic [7:0] CBT_IF_CR  = 8'h00;
  localparam logic [7:0] CBT_IF_CM  = 8'h02;
  localparam logic [7:0] CBT_IF_DA1 = 8'h0E;
  localparam logic [7:0] CBT_IF_DA2 = 8'h10;
  localparam logic [7:0] CBT_IF_DB1 = 8'h12;
  localparam logic [7:0] CBT_IF_DB2 = 8'h14;

  // Reset values
  localparam logic [7:0]  CBT_CTL_RST  = 8'h01;
  localparam logic [15:0] CBT_BT_RST   = 16'h2301;
  localparam logic [3:0]  CBT_PRESCALER_EXTENSION_RST = 4'h0;
  localparam logic [15:0] CBT_CR_RST   = 16'h0001;
  localparam logic [1:0]  CBT_CFG_RST  = 2'h0;

  // Field positions
  localparam int CBT_CTL_INIT   = 0;
  localparam int CBT_CTL_CCE    = 6;
  localparam int CBT_BT_BRP_LSB = 0;
  localparam int CBT_BT_SJW_LSB = 6;
  localparam int CBT_BT_TS1_LSB = 8;
  localparam int CBT_BT_TS2_LSB = 12;
  localparam int CBT_CM_WR      = 7;
  localparam int CBT_CM_CLRVAL  = 3;
  localparam int CBT_CM_TXRQ    = 2;

  typedef enum logic [1:0] {SEG_SYNC, SEG_FIRST_SEGMENT_FIELD, SEG_SECOND_SEGMENT_FIELD} cbt_seg_t;

  // Decode of interface-set registers: {hit, set, field}
  // Field 0 command request, 1 command mask, 2..5 data words
  function automatic logic [4:0] cbt_if_dec(input logic [7:0] idx);
    logic       set_b;
    logic [7:0] rel;
    logic [2:0] fld;
    logic       hit;
    set_b = (idx >= CBT_IDX_IF2);
    rel   = idx - (set_b ? CBT_IDX_IF2 : CBT_IDX_IF1);
    hit   = (idx >= CBT_IDX_IF1);
    fld   = 3'h0;
    case (rel)
      CBT_IF_CR:  fld = 3'h0;
      CBT_IF_CM:  fld = 3'h1;
      CBT_IF_DA1: fld = 3'h2;
      CBT_IF_DA2: fld = 3'h3;
      CBT_IF_DB1: fld = 3'h4;
      CBT_IF_DB2: fld = 3'h5;
      default:    hit = 1'b0;
    endcase
    return {hit, set_b, fld};
  endfunction

endpackage

//--- cbt_clk_div.sv
`timescale 1ns/1ns
`default_nettype none
module cbt_clk_div
  import cbt_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  input  wire logic [1:0] div_sel,
  output logic            tick
);

  logic [2:0] cnt_reg;
  logic [2:0] ratio_mask;

  // Selection 0..3 gives ratio 1, 2, 4, 8
  assign ratio_mask = 3'(({2'b00, 1'b1} << div_sel) - 3'h1);
  assign tick       = ((cnt_reg & ratio_mask) == 3'h0);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      cnt_reg <= 3'h0;
    else if (clk_en)
      cnt_reg <= cnt_reg + 3'h1;
  end

endmodule
`default_nettype wire

//--- cbt_bus_observer.sv
`timescale 1ns/1ns
`default_nettype none
module cbt_bus_observer
  import cbt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        core_tick,
  input  wire logic        tq_pulse,
  input  wire cbt_seg_t    bit_seg,
  output logic      [15:0] sync_cyc,
  output logic      [15:0] ts1_cyc,
  output logic      [15:0] ts2_cyc,
  output logic      [15:0] tq_gap,
  output logic      [15:0] tick_gap
);
  // A far node sees only segment edges, so lengths are kept in cycles
  logic     [15:0] seg_cnt_reg;
  logic     [15:0] tq_cnt_reg;
  logic     [15:0] tick_cnt_reg;
  cbt_seg_t        seg_prev_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seg_cnt_reg  <= 16'h0000;
      tq_cnt_reg   <= 16'h0000;
      tick_cnt_reg <= 16'h0000;
      seg_prev_reg <= SEG_SYNC;
      sync_cyc     <= 16'h0000;
      ts1_cyc      <= 16'h0000;
      ts2_cyc      <= 16'h0000;
      tq_gap       <= 16'h0000;
      tick_gap     <= 16'h0000;
    end else begin
      seg_prev_reg <= bit_seg;
      seg_cnt_reg  <= (bit_seg != seg_prev_reg) ? 16'h0001 :
                      seg_cnt_reg + 16'h0001;
      if (bit_seg != seg_prev_reg) begin
        case (seg_prev_reg)
          SEG_SYNC:  sync_cyc <= seg_cnt_reg;
          SEG_FIRST_SEGMENT_FIELD: ts1_cyc <= seg_cnt_reg;
          default:   ts2_cyc <= seg_cnt_reg;
        endcase
      end
      tq_cnt_reg   <= tq_pulse ? 16'h0000 : tq_cnt_reg + 16'h0001;
      tick_cnt_reg <= core_tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (tq_pulse) tq_gap <= tq_cnt_reg + 16'h0001;
      if (core_tick) tick_gap <= tick_cnt_reg + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- can_clock_bit_timing_access_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module can_clock_bit_timing_access_tb_top
  import cbt_pkg::*;
;
  logic        clk_sys;
  logic        rstn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        core_tick;
  logic        tq_pulse;
  logic        sample_pulse;
  cbt_seg_t    bit_seg;
  logic [15:0] sync_cyc;
  logic [15:0] ts1_cyc;
  logic [15:0] ts2_cyc;
  logic [15:0] tq_gap;
  logic [15:0] tick_gap;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          total_checks;
  int          n_smp;
  int          n_chg;
  cbt_seg_t    seg_hold;

  always #2 clk_sys = ~clk_sys;

  cbt_can_timing #(.OBJ_COUNT(32)) cbt_can_timing_inst (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_tick(core_tick), .tq_pulse(tq_pulse),
    .sample_pulse(sample_pulse), .bit_seg(bit_seg));

  cbt_bus_observer cbt_bus_observer_inst (
    .clk_sys(clk_sys), .rstn(rstn), .core_tick(core_tick),
    .tq_pulse(tq_pulse), .bit_seg(bit_seg), .sync_cyc(sync_cyc),
    .ts1_cyc(ts1_cyc), .ts2_cyc(ts2_cyc), .tq_gap(tq_gap),
    .tick_gap(tick_gap));

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until pready is sampled; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Timeout ends the run through the common verdict
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t no ready", $time);
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    check(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] dofs [4] = '{CBT_IF_DA1, CBT_IF_DA2, CBT_IF_DB1, CBT_IF_DB2};
  int         sel_t [3] = '{0, 1, 0};
  int         prescaler_extension_t [3] = '{0, 0, 1};
  int         tqc_t [3] = '{2, 4, 66};

  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rdchk(CBT_IDX_CTL, 32'h00000001);
    rdchk(CBT_IDX_BT, 32'h00002301);
    rdchk(CBT_IDX_PRESCALER_EXTENSION, 32'h00000000);
    rdchk(CBT_IDX_IF1 + CBT_IF_CR, 32'h00000001);
    rdchk(CBT_IDX_IF2 + CBT_IF_CR, 32'h00000001);
    rdchk(CBT_IDX_CFG, 32'h00000000);
    rdchk(CBT_IDX_STAT, 32'h00000000);
    // Timing stays locked until change enable is set as well
    wr(CBT_IDX_BT, 32'h00001111);
    rdchk(CBT_IDX_BT, 32'h00002301);
    $display("Test reset values done");

    for (int s = 0; s < 4; s++) begin
      wr(CBT_IDX_CFG, 32'(s));
      wr(CBT_IDX_IF1 + CBT_IF_DA1, 32'h0000A5A0 + 32'(s));
      repeat ((1 << s) - 1) @(posedge clk_sys);
      rdchk(CBT_IDX_IF1 + CBT_IF_DA1, 32'h0000A5A0 + 32'(s));
      wr(CBT_IDX_IF1 + CBT_IF_DA2, 32'h00005A50 + 32'(s));
      rdchk(CBT_IDX_IF1 + CBT_IF_DA1, 32'h0000A5A0 + 32'(s));
      check({16'h0000, tick_gap}, 32'(1 << s));
    end
    $display("Test access delay done");

    // Prop 2, phase 2 and 3, jump width 2: fields 3, 2, 1, prescaler low 1
    for (int i = 0; i < 3; i++) begin
      wr(CBT_IDX_CFG, 32'(sel_t[i]));
      wr(CBT_IDX_CTL, 32'h00000041);
      wr(CBT_IDX_BT, 32'h00002341);
      wr(CBT_IDX_PRESCALER_EXTENSION, 32'(prescaler_extension_t[i]));
      rdchk(CBT_IDX_BT, 32'h00002341);
      wr(CBT_IDX_CTL, 32'h00000000);
      // Three bits: one sample point each, at the start of phase two
      n_smp = 0;
      repeat (24 * tqc_t[i]) begin
        @(posedge clk_sys);
        if (sample_pulse === 1'b1 && bit_seg == SEG_SECOND_SEGMENT_FIELD)
          n_smp++;
      end
      check(32'(n_smp), 32'h00000003);
      check({16'h0000, tq_gap}, 32'(tqc_t[i]));
      check({16'h0000, sync_cyc}, 32'(tqc_t[i]));
      check({16'h0000, ts1_cyc}, 32'(4 * tqc_t[i]));
      check({16'h0000, ts2_cyc}, 32'(3 * tqc_t[i]));
      // Enable low must freeze the sequencer; 10 cycles exceed any segment
      if (i == 0) begin
        clk_en <= 1'b0;
        @(posedge clk_sys);
        seg_hold = bit_seg;
        n_chg = 0;
        repeat (10) begin
          @(posedge clk_sys);
          if (bit_seg != seg_hold)
            n_chg++;
        end
        check(32'(n_chg), 32'h00000000);
        clk_en <= 1'b1;
      end
    end
    wr(CBT_IDX_CTL, 32'h00000001);
    $display("Test bit timing done");

    wr(CBT_IDX_IF1 + CBT_IF_CM, 32'h00000080);
    for (int k = 0; k < 4; k++)
      wr(CBT_IDX_IF1 + dofs[k], 32'h00001110 * (k + 1));
    wr(CBT_IDX_IF1 + CBT_IF_CR, 32'h00000005);
    rdchk(CBT_IDX_MV1, 32'h00000010);
    rdchk(CBT_IDX_ND1, 32'h00000010);
    wr(CBT_IDX_IF2 + CBT_IF_CM, 32'h00000000);
    wr(CBT_IDX_IF2 + CBT_IF_CR, 32'h00000005);
    for (int k = 0; k < 4; k++)
      rdchk(CBT_IDX_IF2 + dofs[k], 32'h00001110 * (k + 1));
    wr(CBT_IDX_IF2 + CBT_IF_CM, 32'h00000004);
    wr(CBT_IDX_IF2 + CBT_IF_CR, 32'h00000005);
    rdchk(CBT_IDX_ND1, 32'h00000000);
    wr(CBT_IDX_MV1, 32'h0000FFFF);
    rdchk(CBT_IDX_MV1, 32'h00000010);
    wr(CBT_IDX_IF1 + CBT_IF_CM, 32'h00000084);
    wr(CBT_IDX_IF1 + CBT_IF_CR, 32'h00000020);
    rdchk(CBT_IDX_MV2, 32'h00008000);
    rdchk(CBT_IDX_TR2, 32'h00008000);
    wr(CBT_IDX_IF1 + CBT_IF_CM, 32'h00000088);
    wr(CBT_IDX_IF1 + CBT_IF_CR, 32'h00000020);
    rdchk(CBT_IDX_MV2, 32'h00000000);
    // Offset 4 of a set, between the mask word and the data words, is not mapped
    apb(1'b0, CBT_IDX_IF1 + 8'h04, 32'h00000000);
    check({31'h00000000, err}, 32'h00000001);
    check(rd, 32'h00000000);
    $display("Test message objects done");
    finish_test();
  end
endmodule
`default_nettype wire
